// ==== rtl/ret_rot_pkg.sv ====
// Package with constants and carriers for the return and rotate execution unit.
// Operation
// RULE1: Interrupt return pops stack head into PC.
// RULE2: Interrupt return sets global enable bit 7.
// RULE3: Interrupt return: one word, two cycles.
// RULE4: Plain return pops head, enable unchanged.
// RULE5: Plain return takes two cycles.
// RULE6: Literal return writes eight-bit literal to W.
// RULE7: Literal return loads PC from stack head.
// RULE8: Literal return: two cycles, one word.
// RULE9: Left rotate operand through carry, address 0-127.
// RULE10: Left rotate: 0 to W, 1 to source.
// RULE11: Right rotate operand through carry.
// RULE12: Right rotate: clear to W, set to source.
// RULE13: Left: bit7 to carry; right: bit0 to carry.
// RULE14: Rotates change only carry; returns change none.
package ret_rot_pkg;
  localparam int DATA_W = 8;
  localparam int PC_W = 15;
  localparam int FILE_W = 7;
  localparam int GIE_BIT = 7;
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic READY_RESET = 1'b1;
  localparam logic [1:0] HOLD_RESET = 2'h0;

  typedef enum logic [2:0] {
    OP_NONE,
    INTERRUPT_RETURN_OP,
    PLAIN_RETURN_OP,
    LITERAL_RETURN_OP,
    ROTATE_LEFT_CARRY_OP,
    ROTATE_RIGHT_CARRY_OP
  } op_t;

  typedef struct packed {
    op_t op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic dest_file;
  } instr_t;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;
endpackage

// ==== rtl/return_and_rotate_exec.sv ====
// Executes the three return forms and the two rotate-through-carry operations.
`timescale 1ns/1ps
module return_and_rotate_exec (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input wire ret_rot_pkg::instr_t instr_i,
  input wire logic [14:0] stack_head_entry_i,
  input wire logic [7:0] file_rd_data_i,
  output logic ready_o,
  output logic stack_pop_o,
  output logic pc_load_o,
  output logic [14:0] pc_o,
  output logic [7:0] w_o,
  output logic carry_o,
  output logic [7:0] irq_control_reg_o,
  output logic global_irq_enable_o,
  output ret_rot_pkg::file_wr_t file_wr_o
);
  import ret_rot_pkg::*;

  typedef enum logic {
    IDLE,
    RET_WAIT
  } state_t;

  // Registered state and the next value of each.
  state_t state;
  state_t next_state;
  logic [1:0] hold_count;
  logic [1:0] next_hold_count;
  logic ready;
  logic next_ready;
  logic [14:0] pc;
  logic [14:0] next_pc;
  logic pop;
  logic next_pop;
  logic pc_load;
  logic next_pc_load;
  logic [7:0] w;
  logic [7:0] next_w;
  logic carry;
  logic next_carry;
  logic [7:0] irq_ctrl;
  logic [7:0] next_irq_ctrl;
  file_wr_t fwr;
  file_wr_t next_fwr;

  // Decode of the instruction in hand.
  logic take;
  logic take_return;
  logic take_rotate;
  logic rotate_left;
  logic [7:0] left_bits;
  logic [7:0] right_bits;
  logic [7:0] rot_result;
  logic rot_carry;

  // True for the three codes that pop the call stack.
  function automatic logic is_return(input op_t op);
    case (op)
      INTERRUPT_RETURN_OP: begin
        is_return = 1'b1;
      end
      PLAIN_RETURN_OP: begin
        is_return = 1'b1;
      end
      LITERAL_RETURN_OP: begin
        is_return = 1'b1;
      end
      default: begin
        is_return = 1'b0;
      end
    endcase
  endfunction

  // True for the two rotate-through-carry codes.
  function automatic logic is_rotate(input op_t op);
    case (op)
      ROTATE_LEFT_CARRY_OP: begin
        is_rotate = 1'b1;
      end
      ROTATE_RIGHT_CARRY_OP: begin
        is_rotate = 1'b1;
      end
      default: begin
        is_rotate = 1'b0;
      end
    endcase
  endfunction

  // A new instruction is only taken while no return is still finishing.
  assign take = instr_valid_i && (state == IDLE);
  assign take_return = take && is_return(instr_i.op);
  assign take_rotate = take && is_rotate(instr_i.op);
  assign rotate_left = (instr_i.op == ROTATE_LEFT_CARRY_OP);

  // Both rotated words are built bit by bit; the old carry fills the vacated end.
  assign left_bits[0] = carry; // RULE13
  for (genvar i = 1; i < DATA_W; i++) begin : g_left
    assign left_bits[i] = file_rd_data_i[i - 1]; // RULE9
  end

  assign right_bits[DATA_W - 1] = carry; // RULE13
  for (genvar i = 0; i < DATA_W - 1; i++) begin : g_right
    assign right_bits[i] = file_rd_data_i[i + 1]; // RULE11
  end

  // Pick the direction; the bit leaving the operand becomes the new carry.
  always_comb begin
    if (rotate_left) begin
      rot_result = left_bits; // RULE9
      rot_carry = file_rd_data_i[DATA_W - 1]; // RULE13
    end else begin
      rot_result = right_bits; // RULE11
      rot_carry = file_rd_data_i[0]; // RULE13
    end
  end

  // Sequencing: a return holds off the next instruction for its second cycle.
  always_comb begin
    next_state = state;
    next_hold_count = hold_count;
    next_ready = ready;
    case (state)
      IDLE: begin
        if (take_return) begin
          next_state = RET_WAIT; // RULE3
          next_hold_count = 2'(RET_CYCLES - 1); // RULE5
          next_ready = 1'b0; // RULE8
        end
      end
      RET_WAIT: begin
        // Count down the cycles left in the return.
        if (hold_count <= 2'h1) begin
          next_state = IDLE; // RULE3
          next_hold_count = HOLD_RESET;
          next_ready = 1'b1; // RULE5 RULE8
        end else begin
          next_hold_count = hold_count - 2'h1;
        end
      end
      default: begin
        next_state = IDLE;
        next_hold_count = HOLD_RESET;
        next_ready = READY_RESET;
      end
    endcase
  end

  // Reset leaves the unit ready to take an instruction at the first edge.
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= IDLE;
      hold_count <= HOLD_RESET;
      ready <= READY_RESET;
    end else begin
      state <= next_state;
      hold_count <= next_hold_count;
      ready <= next_ready;
    end
  end

  // Stack pop and fetch-address load pulses, one cycle each.
  always_comb begin
    next_pop = 1'b0;
    next_pc_load = 1'b0;
    if (take_return) begin
      next_pop = 1'b1; // RULE1 RULE4
      next_pc_load = 1'b1; // RULE1 RULE7
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pop <= 1'b0;
      pc_load <= 1'b0;
    end else begin
      pop <= next_pop;
      pc_load <= next_pc_load;
    end
  end

  // Program counter takes the popped return address.
  always_comb begin
    next_pc = pc;
    if (take_return) begin
      next_pc = stack_head_entry_i; // RULE1 RULE4 RULE7
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc <= PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Working register: literal of a literal return or a rotate sent to W.
  always_comb begin
    next_w = w;
    if (take) begin
      case (instr_i.op)
        LITERAL_RETURN_OP: begin
          next_w = instr_i.literal; // RULE6
        end
        ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP: begin
          if (!instr_i.dest_file) begin
            next_w = rot_result; // RULE10 RULE12
          end
        end
        default: begin
          next_w = w;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      w <= W_RESET;
    end else begin
      w <= next_w;
    end
  end

  // Carry is the only flag touched here, and only by a rotate.
  always_comb begin
    next_carry = carry;
    if (take_rotate) begin
      next_carry = rot_carry; // RULE14
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      carry <= CARRY_RESET;
    end else begin
      carry <= next_carry;
    end
  end

  // Interrupt control: only the global enable bit is ever written.
  always_comb begin
    next_irq_ctrl = irq_ctrl;
    if (take) begin
      case (instr_i.op)
        INTERRUPT_RETURN_OP: begin
          next_irq_ctrl[GIE_BIT] = 1'b1; // RULE2
        end
        default: begin
          next_irq_ctrl = irq_ctrl; // RULE4
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_ctrl <= IRQ_CTRL_RESET;
    end else begin
      irq_ctrl <= next_irq_ctrl;
    end
  end

  // File write-back port, a one-cycle strobe with address and data.
  always_comb begin
    next_fwr = '0;
    if (take) begin
      case (instr_i.op)
        ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP: begin
          if (instr_i.dest_file) begin
            next_fwr.we = 1'b1; // RULE10
            next_fwr.addr = instr_i.file_addr; // RULE12
            next_fwr.data = rot_result; // RULE10 RULE12
          end
        end
        default: begin
          next_fwr = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fwr <= '0;
    end else begin
      fwr <= next_fwr;
    end
  end

  // Every output is a register or a single bit of one.
  assign ready_o = ready;
  assign stack_pop_o = pop;
  assign pc_load_o = pc_load;
  assign pc_o = pc;
  assign w_o = w;
  assign carry_o = carry;
  assign irq_control_reg_o = irq_ctrl;
  assign global_irq_enable_o = irq_ctrl[GIE_BIT];
  assign file_wr_o = fwr;
endmodule

// ==== tb/rr_assertions.sv ====
// Checker for the return and rotate execution unit.
`timescale 1ns/1ps
module rr_chk (
  input wire logic clock_i, nrst_i, instr_valid_i, ready_o, stack_pop_o, pc_load_o,
  input wire logic carry_o, global_irq_enable_o,
  input wire ret_rot_pkg::instr_t instr_i,
  input wire logic [14:0] stack_head_entry_i, pc_o,
  input wire logic [7:0] file_rd_data_i, w_o,
  input wire ret_rot_pkg::file_wr_t file_wr_o
);
  import ret_rot_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  wire t = instr_valid_i && ready_o;
  wire ret = t && instr_i.op inside {INTERRUPT_RETURN_OP, PLAIN_RETURN_OP, LITERAL_RETURN_OP};
  wire rl = t && instr_i.op == ROTATE_LEFT_CARRY_OP;
  wire rr = t && instr_i.op == ROTATE_RIGHT_CARRY_OP;
  AST_POP: assert property (ret |=> stack_pop_o && pc_load_o
    && pc_o == $past(stack_head_entry_i)) else $error("bad pop");
  AST_TWO: assert property (ret |=> !ready_o ##1 ready_o)
    else $error("bad return length");
  AST_GIE: assert property (ret && instr_i.op == INTERRUPT_RETURN_OP |=>
    global_irq_enable_o) else $error("enable not set");
  AST_KEEP: assert property (ret && instr_i.op != INTERRUPT_RETURN_OP |=>
    $stable(global_irq_enable_o)) else $error("enable changed");
  AST_LIT: assert property (ret && instr_i.op == LITERAL_RETURN_OP |=>
    w_o == $past(instr_i.literal)) else $error("bad literal");
  AST_RL: assert property (rl |=> carry_o == $past(file_rd_data_i[7]))
    else $error("bad left carry");
  AST_RR: assert property (rr |=> carry_o == $past(file_rd_data_i[0]))
    else $error("bad right carry");
  AST_WB: assert property ((rl || rr) |=> file_wr_o.we == $past(instr_i.dest_file))
    else $error("bad destination");
  AST_FLAG: assert property (ret |=> $stable(carry_o))
    else $error("carry changed");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the return and rotate execution unit.
`timescale 1ns/1ps
module tb_top;
  import ret_rot_pkg::*;
  logic clock_i = 0, nrst_i = 0, instr_valid_i = 0, ready_o, stack_pop_o, pc_load_o, carry_o, global_irq_enable;
  logic [14:0] head = 15'h0000, pc_o;
  logic [7:0] rd = 8'h00, w_o, irq;
  instr_t ins = '0;
  file_wr_t fw;
  int mismatches, checks, ec, ew, epc, eg, r;
  return_and_rotate_exec dut (.clock_i, .nrst_i, .instr_valid_i, .instr_i(ins),
    .stack_head_entry_i(head), .file_rd_data_i(rd), .ready_o, .stack_pop_o, .pc_load_o,
    .pc_o, .w_o, .carry_o, .irq_control_reg_o(irq), .global_irq_enable_o(global_irq_enable), .file_wr_o(fw));
  task automatic chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: %h vs %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input op_t op, input bit v);
    bit isret, isrot;
    isret = v && op inside {INTERRUPT_RETURN_OP, PLAIN_RETURN_OP, LITERAL_RETURN_OP};
    isrot = v && op inside {ROTATE_LEFT_CARRY_OP, ROTATE_RIGHT_CARRY_OP};
    ins = '{op, 8'($urandom), 7'($urandom), 1'($urandom)};
    head = 15'($urandom);
    rd = 8'($urandom);
    instr_valid_i = v;
    @(posedge clock_i);
    r = op == ROTATE_LEFT_CARRY_OP ? {rd, 1'(ec)} : {rd[0], 1'(ec), rd[7:1]};
    if (isrot) begin
      ec = r >> 8;
      if (!ins.dest_file) ew = r & 255;
    end
    if (isret) epc = head;
    if (isret && op == LITERAL_RETURN_OP) ew = ins.literal;
    if (isret && op == INTERRUPT_RETURN_OP) eg = 1;
    @(negedge clock_i);
    chk(w_o, ew);
    chk(carry_o, ec);
    chk({pc_o, stack_pop_o}, {15'(epc), isret});
    chk(pc_load_o, isret);
    chk(irq, {1'(eg), 7'h00});
    chk(global_irq_enable, eg);
    chk(fw.we, isrot && ins.dest_file);
    if (isrot && ins.dest_file) chk({fw.addr, fw.data}, {ins.file_addr, 8'(r)});
    chk(ready_o, !isret);
    if (isret) begin
      ins.op = ROTATE_LEFT_CARRY_OP;
      ins.dest_file = 0;
      @(negedge clock_i);
      chk({stack_pop_o, pc_load_o, ready_o}, 16'h0001);
      chk({carry_o, w_o}, {1'(ec), 8'(ew)});
    end
  endtask
  initial forever #10 clock_i = ~clock_i;
  initial begin
    #20000;
    mismatches++;
    stop_test;
  end
  initial begin
    void'($urandom(32'hC7ED));
    repeat (4) @(negedge clock_i);
    chk({w_o, carry_o, global_irq_enable, ready_o}, 16'h0001);
    chk({irq, stack_pop_o, pc_load_o, fw.we}, 16'h0000);
    chk(pc_o, 16'(PC_RESET));
    nrst_i = 1;
    for (int i = 0; i < 120; i++) run(op_t'($urandom_range(5, 0)), $urandom_range(3, 0) != 0);
    instr_valid_i = 0;
    stop_test;
  end
endmodule
bind return_and_rotate_exec rr_chk chk_i (.clock_i(clock_i), .nrst_i(nrst_i),
  .instr_valid_i(instr_valid_i), .ready_o(ready_o), .stack_pop_o(stack_pop_o),
  .pc_load_o(pc_load_o), .carry_o(carry_o), .global_irq_enable_o(global_irq_enable_o),
  .instr_i(instr_i), .stack_head_entry_i(stack_head_entry_i), .pc_o(pc_o),
  .file_rd_data_i(file_rd_data_i), .w_o(w_o), .file_wr_o(file_wr_o));
